// File: pwed_pkg.sv
// constants, register map and states of the wake and energy-detect block
package pwed_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] MODE_OFS = 4'h0;
  localparam logic [3:0] NLP_OFS = 4'h1;
  localparam logic [3:0] IMASK_OFS = 4'h2;
  localparam logic [3:0] ISRC_OFS = 4'h3;
  localparam logic [3:0] WCSR_OFS = 4'h4;
  localparam logic [3:0] MISC_OFS = 4'h5;
  localparam logic [3:0] ADDRA_OFS = 4'h6;
  localparam logic [3:0] ADDRB_OFS = 4'h7;
  localparam logic [3:0] ADDRC_OFS = 4'h8;
  // mode register
  localparam int MODE_ENERGY_DETECT_POWER_DOWN_BIT = 0;
  localparam int MODE_ENERGY_BIT = 1;
  // nlp register fields
  localparam int NLP_TXEN_BIT = 0;
  localparam int NLP_TXSEL_LSB = 1;
  localparam int NLP_SINGLE_BIT = 3;
  localparam int NLP_RXSEL_LSB = 4;
  // interrupt mask and source bits
  localparam int IRQ_ENERGY_BIT = 7;
  localparam int IRQ_WAKE_BIT = 8;
  // wake control/status fields
  localparam int WCSR_EN_LSB = 0;
  localparam int WCSR_RCV_LSB = 4;
  localparam int WCSR_SELFCLR_BIT = 8;
  localparam int WCSR_CFGD_BIT = 9;
  localparam int WCSR_IND1_LSB = 10;
  localparam int WCSR_IND2_LSB = 12;
  localparam logic [1:0] IND_LINK_ACT = 2'h0;
  localparam logic [1:0] IND_IRQ = 2'h1;
  localparam logic [1:0] IND_PME = 2'h2;
  localparam logic [1:0] IND_LINK_SPD = 2'h3;
  localparam logic [15:0] MISC_RESET = 16'h0064;
  // time base
  localparam int CLK_NS = 20;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = (MS_NS + CLK_NS - 1) / CLK_NS;
  // pulse intervals in ms, indexed by select field
  localparam logic [9:0] TX_IVL_0 = 10'd1000;
  localparam logic [9:0] TX_IVL_1 = 10'd768;
  localparam logic [9:0] TX_IVL_2 = 10'd512;
  localparam logic [9:0] TX_IVL_3 = 10'd256;
  localparam logic [9:0] RX_IVL_0 = 10'd64;
  localparam logic [9:0] RX_IVL_1 = 10'd256;
  localparam logic [9:0] RX_IVL_2 = 10'd512;
  localparam logic [9:0] RX_IVL_3 = 10'd1000;
  // magic frame shape
  localparam logic [2:0] MAGIC_SYNC = 3'd6;
  localparam logic [2:0] MAGIC_LAST_COL = 3'd5;
  localparam logic [4:0] MAGIC_LAST_COPY = 5'd15;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  typedef enum logic {PWED_ACTIVE, PWED_DOWN} pwed_state_type;
endpackage : pwed_pkg

// File: pwed_magic.sv
// magic wake frame scanner
`timescale 1ns/1ns
`default_nettype none
module pwed_magic (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic sof_i,
  input wire logic valid_i,
  input wire logic [7:0] data_i,
  input wire logic [47:0] addr_i,
  output logic found_o
);
  import pwed_pkg::*;
  typedef struct packed {
    logic [2:0] ffcnt;
    logic [2:0] col;
    logic [4:0] copies;
    logic found;
  } pwed_magic_type;
  pwed_magic_type r;
  pwed_magic_type next_r;
  always_comb begin
    logic [7:0] exp_byte;
    next_r = r;
    exp_byte = 8'h00;
    if (sof_i) begin
      next_r = '0;
    end
    exp_byte = addr_i[{next_r.col, 3'b000} +: 8];
    if (valid_i && !next_r.found) begin
      if (next_r.ffcnt == MAGIC_SYNC && data_i == exp_byte) begin
        if (next_r.col == MAGIC_LAST_COL) begin
          next_r.col = 3'd0;
          if (next_r.copies == MAGIC_LAST_COPY) begin
            next_r.found = 1'b1;
          end
          next_r.copies = next_r.copies + 5'd1;
        end else begin
          next_r.col = next_r.col + 3'd1;
        end
      end else if (data_i == ALL_ONES) begin
        if (next_r.col != 3'd0 || next_r.copies != 5'd0) begin
          next_r.ffcnt = 3'd1;
        end else if (next_r.ffcnt != MAGIC_SYNC) begin
          next_r.ffcnt = next_r.ffcnt + 3'd1;
        end
        next_r.col = 3'd0;
        next_r.copies = 5'd0;
      end else begin
        next_r.ffcnt = 3'd0;
        next_r.col = 3'd0;
        next_r.copies = 5'd0;
      end
    end
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign found_o = r.found;
endmodule : pwed_magic
`default_nettype wire

// File: pwed_top.sv
// energy-detect power-down and wake event logic with register port
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module pwed_top #(
  parameter int CYC_MS = pwed_pkg::CYC_PER_MS
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic sw_reset_i,
  input wire logic [pwed_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [pwed_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [pwed_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic line_energy_i,
  input wire logic nlp_rx_i,
  input wire logic pkt_energy_i,
  input wire logic ref_clk_out_mode_i,
  input wire logic rx_sof_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_eof_i,
  input wire logic rx_fcs_len_ok_i,
  input wire logic pattern_hit_i,
  input wire logic link_act_i,
  input wire logic link_speed_i,
  output logic power_down_o,
  output logic tx_enable_o,
  output logic nlp_tx_o,
  output logic ref_clock_out_en_o,
  output logic energy_present_flag_o,
  output logic interrupt_out_n_o,
  output logic power_event_out_n_o,
  output logic indicator_one_o,
  output logic indicator_two_o
);
  import pwed_pkg::*;

  typedef struct packed {
    pwed_state_type state;
    logic energy_detect_power_down_enable_bit;
    logic [5:0] nlp_cfg;
    logic mask_energy;
    logic mask_wake;
    logic src_energy;
    logic src_wake;
    logic [3:0] wake_en;
    logic [3:0] wake_rcv;
    logic self_clr;
    logic wake_cfgd;
    logic [1:0] ind1_sel;
    logic [1:0] ind2_sel;
    logic [15:0] misc_config_reg;
    logic [47:0] wake_addr;
    logic pme;
    logic [15:0] pme_cnt;
    logic [15:0] ms_div;
    logic [9:0] tx_cnt;
    logic nlp_tx;
    logic [9:0] rx_win;
    logic in_frame;
    logic [2:0] byte_cnt;
    logic da_eq;
    logic da_bc;
    logic [DATA_W-1:0] rdata;
  } pwed_regs_type;

  pwed_regs_type r;
  pwed_regs_type next_r;
  logic magic_found;
  logic ms_tick;
  logic irq_any;

  function automatic logic [9:0] ivl_pick(input logic [1:0] sel, input logic is_tx);
    logic [9:0] v;
    v = 10'd0;
    case (sel)
      2'd0: v = is_tx ? TX_IVL_0 : RX_IVL_0;
      2'd1: v = is_tx ? TX_IVL_1 : RX_IVL_1;
      2'd2: v = is_tx ? TX_IVL_2 : RX_IVL_2;
      default: v = is_tx ? TX_IVL_3 : RX_IVL_3;
    endcase
    return v;
  endfunction : ivl_pick

  function automatic logic ind_pick(input logic [1:0] sel, input logic act, input logic spd,
                                    input logic irq_n, input logic pme_n);
    logic v;
    v = act;
    case (sel)
      IND_LINK_ACT: v = act;
      IND_IRQ: v = irq_n;
      IND_PME: v = pme_n;
      default: v = spd;
    endcase
    return v;
  endfunction : ind_pick

  // frames only reach the scanner while the core is up
  pwed_magic u_magic (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .sof_i(rx_sof_i),
    .valid_i(rx_valid_i && r.state == PWED_ACTIVE),
    .data_i(rx_data_i),
    .addr_i(r.wake_addr),
    .found_o(magic_found)
  );

  assign ms_tick = (r.ms_div == 16'(CYC_MS - 1));

  always_comb begin
    logic [3:0] hits;
    logic wake_nlp;
    logic pme_on;
    logic [3:0] rcv_clr;
    logic [2:0] cnt;
    logic eq;
    logic bc;
    next_r = r;
    hits = 4'h0;
    wake_nlp = 1'b0;
    pme_on = 1'b0;
    rcv_clr = 4'h0;
    cnt = 3'd0;
    eq = 1'b0;
    bc = 1'b0;
    next_r.nlp_tx = 1'b0;
    next_r.rdata = '0;
    next_r.ms_div = ms_tick ? 16'h0000 : r.ms_div + 16'h0001;

    // register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        MODE_OFS: next_r.energy_detect_power_down_enable_bit = reg_wdata_i[MODE_ENERGY_DETECT_POWER_DOWN_BIT];
        NLP_OFS: next_r.nlp_cfg = reg_wdata_i[5:0];
        IMASK_OFS: begin
          next_r.mask_energy = reg_wdata_i[IRQ_ENERGY_BIT];
          next_r.mask_wake = reg_wdata_i[IRQ_WAKE_BIT];
        end
        WCSR_OFS: begin
          next_r.wake_en = reg_wdata_i[WCSR_EN_LSB +: 4];
          rcv_clr = reg_wdata_i[WCSR_RCV_LSB +: 4];
          next_r.self_clr = reg_wdata_i[WCSR_SELFCLR_BIT];
          next_r.wake_cfgd = reg_wdata_i[WCSR_CFGD_BIT];
          next_r.ind1_sel = reg_wdata_i[WCSR_IND1_LSB +: 2];
          next_r.ind2_sel = reg_wdata_i[WCSR_IND2_LSB +: 2];
        end
        MISC_OFS: next_r.misc_config_reg = reg_wdata_i;
        ADDRA_OFS: next_r.wake_addr[15:0] = reg_wdata_i;
        ADDRB_OFS: next_r.wake_addr[31:16] = reg_wdata_i;
        ADDRC_OFS: next_r.wake_addr[47:32] = reg_wdata_i;
        default: ;
      endcase
    end
    next_r.wake_rcv = r.wake_rcv & ~rcv_clr;

    // register reads, source flags clear on read
    if (reg_rd_i) begin
      case (reg_addr_i)
        MODE_OFS: begin
          next_r.rdata[MODE_ENERGY_DETECT_POWER_DOWN_BIT] = r.energy_detect_power_down_enable_bit;
          next_r.rdata[MODE_ENERGY_BIT] = (r.state == PWED_ACTIVE);
        end
        NLP_OFS: next_r.rdata[5:0] = r.nlp_cfg;
        IMASK_OFS: begin
          next_r.rdata[IRQ_ENERGY_BIT] = r.mask_energy;
          next_r.rdata[IRQ_WAKE_BIT] = r.mask_wake;
        end
        ISRC_OFS: begin
          next_r.rdata[IRQ_ENERGY_BIT] = r.src_energy;
          next_r.rdata[IRQ_WAKE_BIT] = r.src_wake;
          next_r.src_energy = 1'b0;
          next_r.src_wake = 1'b0;
        end
        WCSR_OFS: begin
          next_r.rdata[WCSR_EN_LSB +: 4] = r.wake_en;
          next_r.rdata[WCSR_RCV_LSB +: 4] = r.wake_rcv;
          next_r.rdata[WCSR_SELFCLR_BIT] = r.self_clr;
          next_r.rdata[WCSR_CFGD_BIT] = r.wake_cfgd;
          next_r.rdata[WCSR_IND1_LSB +: 2] = r.ind1_sel;
          next_r.rdata[WCSR_IND2_LSB +: 2] = r.ind2_sel;
        end
        MISC_OFS: next_r.rdata = r.misc_config_reg;
        ADDRA_OFS: next_r.rdata = r.wake_addr[15:0];
        ADDRB_OFS: next_r.rdata = r.wake_addr[31:16];
        ADDRC_OFS: next_r.rdata = r.wake_addr[47:32];
        default: ;
      endcase
    end

    if (sw_reset_i) begin
      next_r.energy_detect_power_down_enable_bit = 1'b0;
      next_r.nlp_cfg = '0;
      next_r.mask_energy = 1'b0;
      next_r.mask_wake = 1'b0;
    end

    // receive window for the second pulse
    if (r.rx_win != 10'd0 && ms_tick) begin
      next_r.rx_win = r.rx_win - 10'd1;
    end
    if (nlp_rx_i) begin
      next_r.rx_win = ivl_pick(r.nlp_cfg[NLP_RXSEL_LSB +: 2], 1'b0);
    end
    wake_nlp = nlp_rx_i && (r.nlp_cfg[NLP_SINGLE_BIT] || r.rx_win != 10'd0);

    case (r.state)
      PWED_ACTIVE: begin
        next_r.tx_cnt = 10'd0;
        // idle line powers down; stays up when disabled
        if (r.energy_detect_power_down_enable_bit && !line_energy_i) begin
          next_r.state = PWED_DOWN;
          next_r.rx_win = 10'd0;
        end
      end
      PWED_DOWN: begin
        if (r.nlp_cfg[NLP_TXEN_BIT] && ms_tick) begin
          if (r.tx_cnt == 10'd0) begin
            next_r.nlp_tx = 1'b1;
            next_r.tx_cnt = ivl_pick(r.nlp_cfg[NLP_TXSEL_LSB +: 2], 1'b1);
          end else begin
            next_r.tx_cnt = r.tx_cnt - 10'd1;
          end
        end
        if (!r.energy_detect_power_down_enable_bit) begin
          next_r.state = PWED_ACTIVE;
        end else if (pkt_energy_i || wake_nlp) begin
          next_r.state = PWED_ACTIVE;
          next_r.src_energy = 1'b1;
        end
      end
      default: next_r.state = PWED_ACTIVE;
    endcase

    // destination address compare, first byte rides with start
    cnt = rx_sof_i ? 3'd0 : r.byte_cnt;
    eq = rx_sof_i ? 1'b1 : r.da_eq;
    bc = rx_sof_i ? 1'b1 : r.da_bc;
    if (rx_sof_i) begin
      // frames starting while down are dropped
      next_r.in_frame = (r.state == PWED_ACTIVE);
    end
    if (rx_valid_i && cnt != 3'd6) begin
      eq = eq && (rx_data_i == r.wake_addr[{cnt, 3'b000} +: 8]);
      bc = bc && (rx_data_i == ALL_ONES);
      cnt = cnt + 3'd1;
    end
    next_r.byte_cnt = cnt;
    next_r.da_eq = eq;
    next_r.da_bc = bc;

    // each type gated by its enable
    if (rx_eof_i && rx_fcs_len_ok_i && r.in_frame && r.state == PWED_ACTIVE) begin
      hits = r.wake_en & {pattern_hit_i, magic_found,
                          r.da_bc && r.byte_cnt == 3'd6, r.da_eq && r.byte_cnt == 3'd6};
    end
    if (rx_eof_i) begin
      next_r.in_frame = 1'b0;
    end

    // received bits, set wins over clear
    next_r.wake_rcv = next_r.wake_rcv | hits;
    if (hits != 4'h0) begin
      // wake source flag, set wins over read
      next_r.src_wake = 1'b1;
    end

    pme_on = (r.ind1_sel == IND_PME) || (r.ind2_sel == IND_PME);
    if (r.pme && ms_tick && r.pme_cnt != 16'h0000) begin
      next_r.pme_cnt = r.pme_cnt - 16'h0001;
    end
    if (r.pme && r.self_clr && ms_tick && r.pme_cnt == 16'h0000) begin
      next_r.pme = 1'b0;
    end
    if (next_r.wake_rcv == 4'h0) begin
      next_r.pme = 1'b0;
    end
    if (hits != 4'h0 && pme_on) begin
      next_r.pme = 1'b1;
      next_r.pme_cnt = r.misc_config_reg;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '{state: PWED_ACTIVE, misc_config_reg: MISC_RESET, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign irq_any = (r.src_energy && r.mask_energy) || (r.src_wake && r.mask_wake);
  assign interrupt_out_n_o = !irq_any;
  assign power_event_out_n_o = !r.pme;
  assign reg_rdata_o = r.rdata;
  assign power_down_o = (r.state == PWED_DOWN);
  assign tx_enable_o = (r.state == PWED_ACTIVE);
  assign energy_present_flag_o = (r.state == PWED_ACTIVE);
  assign nlp_tx_o = r.nlp_tx;
  assign ref_clock_out_en_o = ref_clk_out_mode_i && (r.state == PWED_ACTIVE);
  assign indicator_one_o = ind_pick(r.ind1_sel, link_act_i, link_speed_i, !irq_any, !r.pme);
  assign indicator_two_o = ind_pick(r.ind2_sel, link_act_i, link_speed_i, !irq_any, !r.pme);
endmodule : pwed_top
`default_nettype wire

// File: pwed_top_asserts.sv
// port checker for the wake and energy-detect block
`timescale 1ns/1ns
`default_nettype none
module pwed_asserts #(
  parameter int CYC_MS = pwed_pkg::CYC_PER_MS
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic sw_reset_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic line_energy_i,
  input wire logic pkt_energy_i,
  input wire logic ref_clk_out_mode_i,
  input wire logic rx_eof_i,
  input wire logic rx_fcs_len_ok_i,
  input wire logic power_down_o,
  input wire logic tx_enable_o,
  input wire logic nlp_tx_o,
  input wire logic ref_clock_out_en_o,
  input wire logic energy_present_flag_o,
  input wire logic interrupt_out_n_o,
  input wire logic power_event_out_n_o
);
  localparam int GAP_MIN = 256 * CYC_MS - 1;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic armed;
  logic [31:0] gap_cnt;
  // cycles since the last link pulse sent while powered down
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      armed <= 1'b0;
      gap_cnt <= 32'h0;
    end else if (!power_down_o || nlp_tx_o) begin
      armed <= power_down_o;
      gap_cnt <= 32'h0;
    end else begin
      gap_cnt <= gap_cnt + 32'h1;
    end
  end
  sequence s_down_pkt;
    power_down_o && pkt_energy_i;
  endsequence
  a_tx_quiet: assert property (
    power_down_o |-> !tx_enable_o && !energy_present_flag_o) else $error("tx while down");
  a_refclk_stop: assert property (
    ref_clock_out_en_o == (ref_clk_out_mode_i && !power_down_o)) else $error("ref clock gate");
  a_enter_idle: assert property (
    $rose(power_down_o) |-> !$past(line_energy_i)) else $error("down with energy");
  a_pkt_wake: assert property (
    s_down_pkt |=> !power_down_o) else $error("no wake on packet");
  a_nlp_down: assert property (
    nlp_tx_o |-> power_down_o || $past(power_down_o)) else $error("pulse while active");
  a_nlp_spacing: assert property (
    nlp_tx_o && armed |-> gap_cnt >= GAP_MIN) else $error("pulses too close");
  a_pme_cause: assert property (
    $fell(power_event_out_n_o) |-> $past(rx_eof_i) && $past(rx_fcs_len_ok_i))
    else $error("power event without frame");
  a_irq_cause: assert property (
    $fell(interrupt_out_n_o) |-> $past(reg_wr_i) || $past(rx_eof_i) || $fell(power_down_o))
    else $error("interrupt without cause");
  a_irq_hold: assert property (
    !interrupt_out_n_o && !reg_rd_i && !reg_wr_i && !sw_reset_i |=> !interrupt_out_n_o)
    else $error("interrupt dropped");
endmodule : pwed_asserts
`default_nettype wire

// File: pwed_partner.sv
// line-side model: link pulses, packet energy and received frames
`timescale 1ns/1ns
`default_nettype none
module pwed_partner (
  input wire logic ref_clk_i,
  output logic line_energy_o,
  output logic nlp_o,
  output logic pkt_o,
  output logic sof_o,
  output logic valid_o,
  output logic [7:0] data_o,
  output logic eof_o,
  output logic ok_o,
  output logic pat_o
);
  logic [7:0] byte_q;
  logic [7:0] noise = 8'h5A;
  // idle data wanders every cycle so a stale byte never looks valid
  assign data_o = valid_o ? byte_q : noise;
  always @(posedge ref_clk_i) noise <= noise + 8'h3B;
  initial begin
    {line_energy_o, nlp_o, pkt_o, sof_o, valid_o, eof_o, ok_o, pat_o} = 8'h80;
    byte_q = 8'h00;
  end
  task automatic energy(input logic e);
    @(posedge ref_clk_i);
    line_energy_o <= e;
  endtask : energy
  // one link pulse or packet energy
  task automatic pulse(input logic pkt);
    @(posedge ref_clk_i);
    pkt_o <= pkt;
    nlp_o <= !pkt;
    @(posedge ref_clk_i);
    pkt_o <= 1'b0;
    nlp_o <= 1'b0;
  endtask : pulse
  task automatic frame(input logic [7:0] b[$], input logic ok, input logic pat);
    for (int i = 0; i < b.size(); i++) begin
      @(posedge ref_clk_i);
      sof_o <= (i == 0);
      valid_o <= 1'b1;
      byte_q <= b[i];
    end
    @(posedge ref_clk_i);
    sof_o <= 1'b0;
    valid_o <= 1'b0;
    @(posedge ref_clk_i);
    eof_o <= 1'b1;
    ok_o <= ok;
    pat_o <= pat;
    @(posedge ref_clk_i);
    {eof_o, ok_o, pat_o} <= 3'h0;
  endtask : frame
endmodule : pwed_partner
`default_nettype wire

// File: pwed_top_tb.sv
// self-checking bench for the wake and energy-detect block
`timescale 1ns/1ns
`default_nettype none
module pwed_top_tb;
  import pwed_pkg::*;
  localparam int CYC = 10;
  logic ref_clk_i, rst_n_i, sw_reset_i, reg_wr_i, reg_rd_i, rd_d;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o, exp_v;
  logic ref_clk_out_mode_i, link_act_i, link_speed_i;
  wire line_energy_i, nlp_rx_i, pkt_energy_i, rx_sof_i, rx_valid_i;
  wire rx_eof_i, rx_fcs_len_ok_i, pattern_hit_i;
  wire [7:0] rx_data_i;
  logic power_down_o, tx_enable_o, nlp_tx_o, ref_clock_out_en_o, energy_present_flag_o;
  logic interrupt_out_n_o, power_event_out_n_o, indicator_one_o, indicator_two_o;
  logic [DATA_W-1:0] exp_q[$];
  logic [47:0] wa;
  int errors, compares;
  pwed_top #(.CYC_MS(CYC)) pwed_top_inst (.*);
  pwed_partner pwed_partner_inst (.ref_clk_i(ref_clk_i), .line_energy_o(line_energy_i),
    .nlp_o(nlp_rx_i), .pkt_o(pkt_energy_i), .sof_o(rx_sof_i), .valid_o(rx_valid_i),
    .data_o(rx_data_i), .eof_o(rx_eof_i), .ok_o(rx_fcs_len_ok_i), .pat_o(pattern_hit_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  task automatic summarize();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input string n, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp=%b got=%b", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    exp_q.push_back(e);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask : settle
  task automatic wait_nlp();
    int n;
    for (n = 0; n < 3000 && nlp_tx_o !== 1'b1; n++) @(negedge ref_clk_i);
    chk("nlp_tx_o", 1'b1, nlp_tx_o);
    if (n == 3000) summarize();
    // step past the one-cycle pulse before looking again
    @(negedge ref_clk_i);
  endtask : wait_nlp
  task automatic send(input logic [47:0] da, input bit magic, input logic ok, input logic pat);
    logic [7:0] q[$];
    for (int i = 0; i < 6; i++) q.push_back(da[8*i +: 8]);
    for (int i = 0; i < 6; i++) q.push_back(8'hA5);
    for (int i = 0; i < 6 && magic; i++) q.push_back(8'hFF);
    for (int i = 0; i < 96 && magic; i++) q.push_back(wa[8*(i%6) +: 8]);
    q.push_back(8'h08);
    pwed_partner_inst.frame(q, ok, pat);
  endtask : send
  always @(posedge ref_clk_i) rd_d <= reg_rd_i;
  always @(negedge ref_clk_i) begin
    if (rd_d === 1'b1) begin
      exp_v = exp_q.pop_front();
      compares++;
      if (reg_rdata_o !== exp_v) begin
        errors++;
        $display("[ERR] reg_rdata_o exp=%h got=%h", exp_v, reg_rdata_o);
      end
    end
  end
  initial begin
    repeat (100000) @(posedge ref_clk_i);
    errors++;
    summarize();
  end
  initial begin
    {rst_n_i, sw_reset_i, reg_wr_i, reg_rd_i, link_act_i, link_speed_i} = 6'h00;
    reg_addr_i = 4'h0;
    reg_wdata_i = 16'h0000;
    ref_clk_out_mode_i = 1'b1;
    errors = 0;
    compares = 0;
    repeat (6) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    void'($urandom(21));
    wa = 48'({$urandom, $urandom});
    wa[0] = 1'b0;
    link_act_i <= 1'b1;
    wr(ISRC_OFS, 16'hFFFF);
    wr(4'hF, 16'hFFFF);
    for (int i = 0; i < 16; i++) rd(i[3:0], i == 0 ? 16'h0002 : (i == 5 ? MISC_RESET : 16'h0));
    settle(1);
    chk("indicator_one_o", link_act_i, indicator_one_o);
    pwed_partner_inst.energy(1'b0);
    wr(IMASK_OFS, 16'h0080);
    wr(NLP_OFS, 16'h0007);
    settle(20);
    chk("power_down_o", 1'b0, power_down_o);
    wr(MODE_OFS, 16'h0001);
    settle(2);
    chk("power_down_o", 1'b1, power_down_o);
    chk("tx_enable_o", 1'b0, tx_enable_o);
    chk("energy_present_flag_o", 1'b0, energy_present_flag_o);
    chk("ref_clock_out_en_o", 1'b0, ref_clock_out_en_o);
    wait_nlp();
    wait_nlp();
    pwed_partner_inst.pulse(1'b0);
    settle(50);
    chk("power_down_o", 1'b1, power_down_o);
    pwed_partner_inst.energy(1'b1);
    pwed_partner_inst.pulse(1'b0);
    settle(3);
    chk("power_down_o", 1'b0, power_down_o);
    chk("interrupt_out_n_o", 1'b0, interrupt_out_n_o);
    chk("energy_present_flag_o", 1'b1, energy_present_flag_o);
    rd(ISRC_OFS, 16'h0080);
    settle(2);
    chk("interrupt_out_n_o", 1'b1, interrupt_out_n_o);
    wr(NLP_OFS, 16'h0008);
    for (int k = 0; k < 2; k++) begin
      pwed_partner_inst.energy(1'b0);
      settle(3);
      chk("power_down_o", 1'b1, power_down_o);
      pwed_partner_inst.energy(1'b1);
      pwed_partner_inst.pulse(k[0]);
      settle(3);
      chk("power_down_o", 1'b0, power_down_o);
    end
    wr(MODE_OFS, 16'h0000);
    rd(ISRC_OFS, 16'h0080);
    // address, enables, then only the wake mask
    wr(ADDRA_OFS, wa[15:0]);
    wr(ADDRB_OFS, wa[31:16]);
    wr(ADDRC_OFS, wa[47:32]);
    wr(WCSR_OFS, 16'h180F);
    wr(IMASK_OFS, 16'h0100);
    for (int k = 0; k < 4; k++) begin
      send(k == 1 ? 48'hFFFFFFFFFFFF : (k == 0 ? wa : wa ^ 48'h100), k == 2, 1'b1, k == 3);
      settle(2);
      chk("indicator_one_o", 1'b0, indicator_one_o);
      chk("power_event_out_n_o", 1'b0, power_event_out_n_o);
      chk("indicator_two_o", 1'b0, indicator_two_o);
      rd(ISRC_OFS, 16'h0100);
      rd(WCSR_OFS, 16'h180F | (16'h0010 << k));
      wr(WCSR_OFS, 16'h180F | (16'h0010 << k));
      settle(2);
      chk("power_event_out_n_o", 1'b1, power_event_out_n_o);
      chk("interrupt_out_n_o", 1'b1, interrupt_out_n_o);
    end
    send(wa, 1'b0, 1'b0, 1'b0);
    settle(2);
    chk("power_event_out_n_o", 1'b1, power_event_out_n_o);
    wr(WCSR_OFS, 16'h180D);
    send(48'hFFFFFFFFFFFF, 1'b0, 1'b1, 1'b0);
    settle(2);
    chk("power_event_out_n_o", 1'b1, power_event_out_n_o);
    wr(MISC_OFS, 16'h0002);
    wr(WCSR_OFS, 16'h190F);
    send(48'hFFFFFFFFFFFF, 1'b0, 1'b1, 1'b0);
    settle(2);
    chk("power_event_out_n_o", 1'b0, power_event_out_n_o);
    settle(40);
    chk("power_event_out_n_o", 1'b1, power_event_out_n_o);
    rd(WCSR_OFS, 16'h192F);
    wr(WCSR_OFS, 16'h3230);
    @(posedge ref_clk_i);
    sw_reset_i <= 1'b1;
    @(posedge ref_clk_i);
    sw_reset_i <= 1'b0;
    rd(WCSR_OFS, 16'h3200);
    rd(ADDRA_OFS, wa[15:0]);
    rd(IMASK_OFS, 16'h0000);
    // random indicator sources and clock-out mode while the core is up
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk_i);
      {link_act_i, link_speed_i, ref_clk_out_mode_i} <= 3'($urandom);
      settle(1);
      chk("indicator_one_o", link_act_i, indicator_one_o);
      chk("indicator_two_o", link_speed_i, indicator_two_o);
      chk("ref_clock_out_en_o", ref_clk_out_mode_i, ref_clock_out_en_o);
    end
    settle(3);
    summarize();
  end
endmodule : pwed_top_tb
bind pwed_top pwed_asserts #(.CYC_MS(CYC_MS)) pwed_asserts_inst (.*);
`default_nettype wire
